/* File: hdl/div_if.sv */
`timescale 1ns/1ps
interface div_if #(parameter int W = 56);
	logic         start;
	logic [W-1:0] dividend;
	logic [W-1:0] divisor;
	logic         done;
	logic [W-1:0] quotient;

	modport client (output start, output dividend, output divisor, input done, input quotient);
	modport server (input start, input dividend, input divisor, output done, output quotient);
endinterface

/* File: hdl/health_attribute_record_builder.sv */
`timescale 1ns/1ps
module health_attribute_record_builder #(
	parameter int NUM_CHIPS     = 4,
	parameter int SPARE_W       = 16,
	parameter int TARGET_ERASES = 3000,
	parameter int NUM_BLOCKS    = 4096
) (
	input  wire logic                       ref_clk,
	input  wire logic                       resetn,
	input  wire logic [NUM_CHIPS*SPARE_W-1:0] chip_init_spares,
	input  wire logic [NUM_CHIPS*SPARE_W-1:0] chip_cur_spares,
	input  wire logic                       erase_evt,
	input  wire logic                       ecc_corr_evt,
	input  wire logic                       ecc_uncorr_evt,
	input  wire logic                       crc_err_evt,
	input  wire health_pkg::byte_t          spare_thr,
	input  wire health_pkg::byte_t          erase_thr,
	input  wire logic                       rd_en,
	input  wire health_pkg::rec_sel_t       rd_sel,
	input  wire health_pkg::byte_idx_t      rd_byte,
	output logic [7:0]                      rd_data_r,
	output logic                            rd_valid_r,
	input  wire logic                       status_req,
	output logic                            status_valid_r,
	output logic                            status_exceeded_r
);
	import health_pkg::*;

	localparam int IDX_W = (NUM_CHIPS > 1) ? $clog2(NUM_CHIPS) : 1;

	// Sizes the datapath cannot serve are refused at elaboration, not discovered in use.
	if (NUM_CHIPS < 1 || SPARE_W < 1 || SPARE_W > SUM_W)
		$error("chip count or spare width out of range");
	if (TARGET_ERASES < 1 || NUM_BLOCKS < 1)
		$error("erase target and block count must be positive");

	div_if #(.W(DIV_W)) dv ();

	seq_divider #(.W(DIV_W)) u_div (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.dv      (dv)
	);

	scan_state_t         state_r;
	logic [IDX_W-1:0]    chip_idx_r;
	logic [SPARE_W-1:0]  sel_init;
	logic [SPARE_W-1:0]  sel_cur;
	logic                last_chip;
	logic [7:0]          quo_pct;
	logic [7:0]          acc_pct_r;
	logic [SUM_W-1:0]    acc_init_r;
	logic [SUM_W-1:0]    acc_cur_r;
	logic [SPARE_W-1:0]  acc_min_cur_r;
	logic [SPARE_W-1:0]  acc_min_init_r;
	logic [SUM_W:0]      add_init;
	logic [SUM_W:0]      add_cur;
	logic [7:0]          spare_pct_r;
	logic [7:0]          spare_worst_r;
	logic [SUM_W-1:0]    sum_init_r;
	logic [SUM_W-1:0]    sum_cur_r;
	logic [SPARE_W-1:0]  worst_cur_r;
	logic [SPARE_W-1:0]  worst_init_r;
	logic [7:0]          life_r;
	logic [7:0]          life_worst_r;
	logic [7:0]          life_nxt;
	logic [ERASE_W-1:0]  erase_cnt_r;
	logic [CNT_W-1:0]    ecc_all_r;
	logic [CNT_W-1:0]    ecc_corr_r;
	logic [CNT_W-1:0]    crc_r;
	logic [CNT_W:0]      ecc_all_sum;
	logic [REC_BITS-1:0] rec [NUM_RECS];
	logic [REC_BITS-1:0] rec_sel;
	logic [7:0]          rd_data_nxt;

	// Pick the chip under scan; chips sit side by side in the flat vectors.
	assign sel_init  = chip_init_spares[chip_idx_r*SPARE_W +: SPARE_W];
	assign sel_cur   = chip_cur_spares[chip_idx_r*SPARE_W +: SPARE_W];
	assign last_chip = chip_idx_r == IDX_W'(NUM_CHIPS - 1);

	// A chip with more spares than it started with, or none to begin with, reads full.
	assign quo_pct = (dv.quotient > DIV_W'(PCT_FULL)) ? PCT_FULL : dv.quotient[7:0];

	// Remaining life falls to zero once the used share reaches one hundred percent.
	assign life_nxt = (dv.quotient >= DIV_W'(PCT_FULL)) ? BYTE_ZERO
		: 8'(PCT_FULL - dv.quotient[7:0]);

	// Spare sums saturate rather than wrap if many large chips are present.
	assign add_init = {1'b0, acc_init_r} + (SUM_W + 1)'(sel_init);
	assign add_cur  = {1'b0, acc_cur_r} + (SUM_W + 1)'(sel_cur);

	// Divider requests: one per chip for the spare percentage, then one for the life estimate.
	always_comb
	begin
		dv.start    = (state_r == ST_CHIP) || (state_r == ST_LIFE);
		dv.dividend = DIV_W'(sel_cur) * DIV_W'(PCT_FULL);
		dv.divisor  = DIV_W'(sel_init);
		if (state_r == ST_LIFE || state_r == ST_LIFE_WAIT)
		begin
			dv.dividend = DIV_W'(erase_cnt_r) * DIV_W'(PCT_FULL);
			dv.divisor  = DIV_W'(TARGET_ERASES) * DIV_W'(NUM_BLOCKS);
		end
	end

	// Refresh sequencer runs continuously so records track normal operation.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r    <= ST_CHIP;
			chip_idx_r <= '0;
		end
		else
		begin
			case (state_r)
				ST_CHIP:
					state_r <= ST_CHIP_WAIT;
				ST_CHIP_WAIT:
					if (dv.done)
					begin
						chip_idx_r <= last_chip ? '0 : chip_idx_r + IDX_W'(1);
						state_r    <= last_chip ? ST_LIFE : ST_CHIP;
					end
				ST_LIFE:
					state_r <= ST_LIFE_WAIT;
				ST_LIFE_WAIT:
					if (dv.done)
						state_r <= ST_CHIP;
				default:
					state_r <= ST_CHIP;
			endcase
		end
	end

	// Per-pass accumulators; the first chip of a pass restarts them.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_pct_r      <= PCT_FULL;
			acc_init_r     <= '0;
			acc_cur_r      <= '0;
			acc_min_cur_r  <= '0;
			acc_min_init_r <= '0;
		end
		else if (state_r == ST_CHIP_WAIT && dv.done)
		begin
			if (chip_idx_r == '0 || quo_pct < acc_pct_r)
				acc_pct_r <= quo_pct;
			acc_init_r <= (chip_idx_r == '0) ? SUM_W'(sel_init)
				: (add_init[SUM_W] ? '1 : add_init[SUM_W-1:0]);
			acc_cur_r  <= (chip_idx_r == '0) ? SUM_W'(sel_cur)
				: (add_cur[SUM_W] ? '1 : add_cur[SUM_W-1:0]);
			if (chip_idx_r == '0 || sel_cur < acc_min_cur_r)
			begin
				acc_min_cur_r  <= sel_cur;
				acc_min_init_r <= sel_init;
			end
		end
	end

	// Publish a finished pass at once so readers never see a half-built snapshot.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			spare_pct_r   <= PCT_FULL;
			spare_worst_r <= PCT_FULL;
			sum_init_r    <= '0;
			sum_cur_r     <= '0;
			worst_cur_r   <= '0;
			worst_init_r  <= '0;
			life_r        <= PCT_FULL;
			life_worst_r  <= PCT_FULL;
		end
		else if (state_r == ST_LIFE_WAIT && dv.done)
		begin
			spare_pct_r  <= acc_pct_r;
			if (acc_pct_r < spare_worst_r)
				spare_worst_r <= acc_pct_r;
			sum_init_r   <= acc_init_r;
			sum_cur_r    <= acc_cur_r;
			worst_cur_r  <= acc_min_cur_r;
			worst_init_r <= acc_min_init_r;
			life_r       <= life_nxt;
			if (life_nxt < life_worst_r)
				life_worst_r <= life_nxt;
		end
	end

	// Event counters hold at all ones instead of wrapping to a misleading small value.
	assign ecc_all_sum = {1'b0, ecc_all_r} + (CNT_W + 1)'(ecc_corr_evt)
		+ (CNT_W + 1)'(ecc_uncorr_evt);

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			erase_cnt_r <= '0;
			ecc_all_r   <= '0;
			ecc_corr_r  <= '0;
			crc_r       <= '0;
		end
		else
		begin
			if (erase_evt && erase_cnt_r != '1)
				erase_cnt_r <= erase_cnt_r + ERASE_W'(1);
			ecc_all_r <= ecc_all_sum[CNT_W] ? '1 : ecc_all_sum[CNT_W-1:0];
			if (ecc_corr_evt && ecc_corr_r != '1)
				ecc_corr_r <= ecc_corr_r + CNT_W'(1);
			if (crc_err_evt && crc_r != '1)
				crc_r <= crc_r + CNT_W'(1);
		end
	end

	// Records are assembled byte 0 at the low end, so each field lands low byte first.
	assign rec[REC_SPARE]    = {BYTE_ZERO, sum_cur_r, sum_init_r, spare_worst_r, spare_pct_r,
		FLAGS_PREFAIL, ID_SPARE};
	assign rec[REC_WORST]    = {BYTE_ZERO, SUM_W'(worst_cur_r), SUM_W'(worst_init_r), PCT_FULL,
		PCT_FULL, FLAGS_PREFAIL, ID_WORST};
	assign rec[REC_ERASE]    = {BYTE_ZERO, erase_cnt_r, life_worst_r, life_r,
		FLAGS_PREFAIL, ID_ERASE};
	assign rec[REC_ECC_ALL]  = {BYTE_ZERO, 16'h0000, ecc_all_r, PCT_FULL, PCT_FULL,
		FLAGS_ADVISORY, ID_ECC_ALL};
	assign rec[REC_ECC_CORR] = {BYTE_ZERO, 16'h0000, ecc_corr_r, PCT_FULL, PCT_FULL,
		FLAGS_ADVISORY, ID_ECC_CORR};
	assign rec[REC_CRC]      = {BYTE_ZERO, 16'h0000, crc_r, PCT_FULL, PCT_FULL,
		FLAGS_ADVISORY, ID_CRC};

	// Out-of-range slots and bytes past the record read as zero.
	always_comb
	begin
		rec_sel     = (rd_sel < rec_sel_t'(NUM_RECS)) ? rec[rd_sel] : '0;
		rd_data_nxt = BYTE_ZERO;
		if (rd_byte <= BYTE_LAST)
			rd_data_nxt = rec_sel[rd_byte*8 +: 8];
	end

	// Byte read port, answered on the following edge.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_data_r  <= BYTE_ZERO;
			rd_valid_r <= 1'b0;
		end
		else
		begin
			rd_valid_r <= rd_en;
			if (rd_en)
				rd_data_r <= rd_data_nxt;
		end
	end

	// Return status looks only at the two pre-failure values; error counts never enter.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			status_valid_r    <= 1'b0;
			status_exceeded_r <= 1'b0;
		end
		else
		begin
			status_valid_r <= status_req;
			if (status_req)
				status_exceeded_r <= (spare_pct_r < spare_thr)
					|| (life_r < erase_thr);
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_status_ask;
		status_req && (spare_pct_r < spare_thr || life_r < erase_thr);
	endsequence

	sequence s_status_clear;
		status_req && spare_pct_r >= spare_thr && life_r >= erase_thr;
	endsequence

	sequence s_read(rec_sel_t s, byte_idx_t b);
		rd_en && rd_sel == s && rd_byte == b;
	endsequence

	a_status_exceeded: assert property (s_status_ask |=>
		status_valid_r && status_exceeded_r)
		else $error("threshold crossing not reported");

	a_status_erase: assert property (status_req && life_r < erase_thr |=>
		status_exceeded_r)
		else $error("erase threshold crossing not reported");

	a_status_errors: assert property (s_status_clear |=> !status_exceeded_r)
		else $error("status raised without a pre-failure cause");

	a_spare_ident: assert property (s_read(REC_SPARE, BYTE_ID) |=>
		rd_valid_r && rd_data_r == ID_SPARE)
		else $error("spare record identifier wrong");

	a_worst_fixed: assert property (s_read(REC_WORST, BYTE_WORST) |=>
		rd_data_r == PCT_FULL)
		else $error("worst-chip value byte not fixed");

	a_advisory_value: assert property (rd_en && rd_sel >= REC_ECC_ALL && rd_sel <= REC_CRC
		&& rd_byte == BYTE_VALUE |=> rd_data_r == PCT_FULL)
		else $error("advisory value byte not fixed");

	a_last_byte_zero: assert property (rd_en && rd_byte == BYTE_LAST |=>
		rd_data_r == BYTE_ZERO)
		else $error("reserved byte not zero");

	a_corr_count: assert property (ecc_corr_evt && ecc_corr_r != '1 |=>
		ecc_corr_r == $past(ecc_corr_r) + CNT_W'(1))
		else $error("correctable count did not advance");

	a_total_count: assert property (ecc_corr_evt && ecc_uncorr_evt && ecc_all_r < 32'hfffffff0
		|=> ecc_all_r == $past(ecc_all_r) + CNT_W'(2))
		else $error("total count missed an event");

	a_pct_bound: assert property (spare_pct_r <= PCT_FULL && life_r <= PCT_FULL)
		else $error("percentage above one hundred");
endmodule

/* File: hdl/health_pkg.sv */
package health_pkg;

	// Attribute identifiers placed in byte 0 of each record.
	localparam logic [7:0]  ID_SPARE       = 8'hc4;
	localparam logic [7:0]  ID_WORST       = 8'hd5;
	localparam logic [7:0]  ID_ERASE       = 8'he5;
	localparam logic [7:0]  ID_ECC_ALL     = 8'hcb;
	localparam logic [7:0]  ID_ECC_CORR    = 8'hcc;
	localparam logic [7:0]  ID_CRC         = 8'hc7;

	// Flag words carried in bytes 1 and 2.
	localparam logic [15:0] FLAGS_PREFAIL  = 16'h0003;
	localparam logic [15:0] FLAGS_ADVISORY = 16'h0002;

	// Full-health value, also the reset value of every percentage.
	localparam logic [7:0]  PCT_FULL       = 8'h64;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;

	// Record geometry and field widths.
	localparam int          REC_BYTES      = 12;
	localparam int          REC_BITS       = REC_BYTES * 8;
	localparam int          NUM_RECS       = 6;
	localparam int          CNT_W          = 32;
	localparam int          ERASE_W        = 48;
	localparam int          SUM_W          = 24;
	localparam int          DIV_W          = 56;

	// A division takes one cycle per quotient bit.
	localparam int          DIV_CYCLES     = DIV_W;

	typedef logic [2:0] rec_sel_t;
	typedef logic [3:0] byte_idx_t;
	typedef logic [7:0] byte_t;

	// Record slots in the order they sit in the attribute section.
	localparam rec_sel_t    REC_SPARE      = 3'h0;
	localparam rec_sel_t    REC_WORST      = 3'h1;
	localparam rec_sel_t    REC_ERASE      = 3'h2;
	localparam rec_sel_t    REC_ECC_ALL    = 3'h3;
	localparam rec_sel_t    REC_ECC_CORR   = 3'h4;
	localparam rec_sel_t    REC_CRC        = 3'h5;

	// Byte positions inside a record.
	localparam byte_idx_t   BYTE_ID        = 4'h0;
	localparam byte_idx_t   BYTE_VALUE     = 4'h3;
	localparam byte_idx_t   BYTE_WORST     = 4'h4;
	localparam byte_idx_t   BYTE_LAST      = 4'hb;

	// Background refresh sequencer, Gray coded around its loop.
	typedef enum logic [1:0] {
		ST_CHIP      = 2'b00,
		ST_CHIP_WAIT = 2'b01,
		ST_LIFE      = 2'b11,
		ST_LIFE_WAIT = 2'b10
	} scan_state_t;

endpackage

/* File: hdl/seq_divider.sv */
`timescale 1ns/1ps
module seq_divider #(
	parameter int W = 56
) (
	input wire logic ref_clk,
	input wire logic resetn,
	div_if.server    dv
);
	import health_pkg::*;

	localparam int CW = $clog2(W + 1);

	logic [W:0]   rem_r;
	logic [W-1:0] quo_r;
	logic [W-1:0] den_r;
	logic [CW-1:0] cnt_r;
	logic         busy_r;
	logic         done_r;
	logic [W:0]   shifted;
	logic         fits;

	// Fewer quotient bits could not fill the 8-bit percentage byte, so refuse them at elaboration.
	if (W < 8)
		$error("seq_divider needs at least 8 quotient bits");

	// Restoring division, one quotient bit per cycle; a zero divisor yields all ones.
	assign shifted = {rem_r[W-1:0], quo_r[W-1]};
	assign fits    = shifted >= {1'b0, den_r};

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rem_r  <= '0;
			quo_r  <= '0;
			den_r  <= '0;
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			if (!busy_r && dv.start)
			begin
				rem_r  <= '0;
				quo_r  <= dv.dividend;
				den_r  <= dv.divisor;
				cnt_r  <= CW'(W);
				busy_r <= 1'b1;
			end
			else if (busy_r)
			begin
				rem_r  <= fits ? (shifted - {1'b0, den_r}) : shifted;
				quo_r  <= {quo_r[W-2:0], fits};
				cnt_r  <= cnt_r - CW'(1);
				if (cnt_r == CW'(1))
				begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end

	assign dv.done     = done_r;
	assign dv.quotient = quo_r;

	// The sequencer waits for done rather than counting cycles; done is registered on the same edge as the last step.
	a_div_latency: assert property (@(posedge ref_clk) disable iff (!resetn)
		(dv.start && !busy_r) |-> ##57 dv.done)
		else $error("divider result not ready on time");
endmodule

/* File: verification/smart_host_model.sv */
`timescale 1ns/1ps
// Host side of the attribute read path: fetches whole records and polls the status result.
module smart_host_model (
	input  wire logic              ref_clk,
	input  wire logic [7:0]        rd_data_r,
	input  wire logic              rd_valid_r,
	input  wire logic              status_valid_r,
	input  wire logic              status_exceeded_r,
	output logic                   rd_en,
	output health_pkg::rec_sel_t   rd_sel,
	output health_pkg::byte_idx_t  rd_byte,
	output logic                   status_req
);
	import health_pkg::*;

	// Idle values at time zero so no request is seen during reset.
	initial
	begin
		rd_en = 1'b0;
		rd_sel = REC_SPARE;
		rd_byte = BYTE_ID;
		status_req = 1'b0;
	end

	// Reads bytes 0 to 15 back to back; a byte whose valid pulse is missing becomes unknown,
	// so a late or absent answer can never pass for a match.
	task automatic read_rec(input rec_sel_t sel, output logic [127:0] rec);
		for (int i = 0; i <= 16; i++)
		begin
			@(posedge ref_clk);
			rd_en <= (i < 16);
			rd_sel <= sel;
			rd_byte <= byte_idx_t'(i);
			#1;
			if (i > 0)
				rec[(i-1)*8 +: 8] = (rd_valid_r === 1'b1) ? rd_data_r : 8'hxx;
		end
	endtask

	// One query; the answer must be present in the cycle right after the request.
	task automatic query(output logic ex);
		@(posedge ref_clk);
		status_req <= 1'b1;
		@(posedge ref_clk);
		status_req <= 1'b0;
		#1;
		ex = (status_valid_r === 1'b1) ? status_exceeded_r : 1'bx;
	endtask
endmodule

/* File: verification/test_health_attribute_record_builder.sv */
`timescale 1ns/1ps
module test_health_attribute_record_builder;
	import health_pkg::*;

	logic                ref_clk = 1'b0;
	logic                resetn = 1'b0;
	logic [63:0]         init_sp = {16'd100, 16'd0, 16'd200, 16'd100};
	logic [63:0]         cur_sp = {16'd40, 16'd60, 16'd50, 16'd80};
	logic                erase_evt = 1'b0;
	logic                ecc_corr_evt = 1'b0;
	logic                ecc_uncorr_evt = 1'b0;
	logic                crc_err_evt = 1'b0;
	byte_t               spare_thr = 8'h00;
	byte_t               erase_thr = 8'h00;
	logic                rd_en;
	rec_sel_t            rd_sel;
	byte_idx_t           rd_byte;
	logic [7:0]          rd_data_r;
	logic                rd_valid_r;
	logic                status_req;
	logic                status_valid_r;
	logic                status_exceeded_r;
	int                  bad_count = 0;
	int                  checked = 0;
	logic [127:0]        r;

	// Clock at 20 MHz.
	always #25 ref_clk = ~ref_clk;

	// One target erase on each of a hundred blocks makes each erase cost one percent of life.
	health_attribute_record_builder #(
		.NUM_CHIPS     (4),
		.SPARE_W       (16),
		.TARGET_ERASES (1),
		.NUM_BLOCKS    (100)
	) dut (
		.ref_clk           (ref_clk),
		.resetn            (resetn),
		.chip_init_spares  (init_sp),
		.chip_cur_spares   (cur_sp),
		.erase_evt         (erase_evt),
		.ecc_corr_evt      (ecc_corr_evt),
		.ecc_uncorr_evt    (ecc_uncorr_evt),
		.crc_err_evt       (crc_err_evt),
		.spare_thr         (spare_thr),
		.erase_thr         (erase_thr),
		.rd_en             (rd_en),
		.rd_sel            (rd_sel),
		.rd_byte           (rd_byte),
		.rd_data_r         (rd_data_r),
		.rd_valid_r        (rd_valid_r),
		.status_req        (status_req),
		.status_valid_r    (status_valid_r),
		.status_exceeded_r (status_exceeded_r)
	);

	smart_host_model host (
		.ref_clk           (ref_clk),
		.rd_data_r         (rd_data_r),
		.rd_valid_r        (rd_valid_r),
		.status_valid_r    (status_valid_r),
		.status_exceeded_r (status_exceeded_r),
		.rd_en             (rd_en),
		.rd_sel            (rd_sel),
		.rd_byte           (rd_byte),
		.status_req        (status_req)
	);

	// Expected record image, byte 0 in the low bits; bytes 11 to 15 are zero.
	function automatic logic [127:0] mk(byte_t id, logic [15:0] fl, byte_t v, byte_t w,
		logic [47:0] raw);
		return {40'h0, raw, w, v, fl, id};
	endfunction

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Overlapping pulses, including a cycle with both ECC kinds at once.
	task automatic t_events;
		@(posedge ref_clk);
		{erase_evt, ecc_corr_evt, ecc_uncorr_evt, crc_err_evt} <= 4'hf;
		@(posedge ref_clk);
		ecc_uncorr_evt <= 1'b0;
		@(posedge ref_clk);
		ecc_corr_evt <= 1'b0;
		ecc_uncorr_evt <= 1'b1;
		@(posedge ref_clk);
		erase_evt <= 1'b0;
		ecc_uncorr_evt <= 1'b0;
		@(posedge ref_clk);
		crc_err_evt <= 1'b0;
		host.read_rec(REC_ECC_ALL, r);
		check(r, mk(ID_ECC_ALL, FLAGS_ADVISORY, PCT_FULL, PCT_FULL, 48'd4));
		host.read_rec(REC_ECC_CORR, r);
		check(r, mk(ID_ECC_CORR, FLAGS_ADVISORY, PCT_FULL, PCT_FULL, 48'd2));
		host.read_rec(REC_CRC, r);
		check(r, mk(ID_CRC, FLAGS_ADVISORY, PCT_FULL, PCT_FULL, 48'd4));
	endtask

	// Chip 1 holds the lowest percentage, chip 3 the fewest spares, chip 2 has none initially.
	task automatic t_spares;
		host.read_rec(REC_SPARE, r);
		check(r, mk(ID_SPARE, FLAGS_PREFAIL, 8'h19, 8'h19, {24'd230, 24'd400}));
		host.read_rec(REC_WORST, r);
		check(r, mk(ID_WORST, FLAGS_PREFAIL, PCT_FULL, PCT_FULL, {24'd40, 24'd100}));
	endtask

	// Three erases out of a budget of one hundred leave 97 percent of life.
	task automatic t_erase;
		host.read_rec(REC_ERASE, r);
		check(r, mk(ID_ERASE, FLAGS_PREFAIL, 8'd97, 8'd97, 48'd3));
	endtask

	// Slots past the last record read as zero in every byte.
	task automatic t_invalid;
		host.read_rec(3'h6, r);
		check(r, 128'h0);
		host.read_rec(3'h7, r);
		check(r, 128'h0);
	endtask

	task automatic st(input byte_t s, input byte_t e, input logic exp);
		logic ex;
		@(posedge ref_clk);
		spare_thr <= s;
		erase_thr <= e;
		host.query(ex);
		check({127'h0, ex}, {127'h0, exp});
	endtask

	// Thresholds at and one above each value; error counts are nonzero throughout.
	task automatic t_status;
		st(8'd26, 8'd0, 1'b1);
		st(8'd25, 8'd97, 1'b0);
		st(8'd25, 8'd98, 1'b1);
		st(8'd0, 8'd0, 1'b0);
	endtask

	// A mid-run reset must bring back the full-health snapshot before the next pass ends.
	task automatic t_reset;
		@(negedge ref_clk);
		resetn = 1'b0;
		repeat (3) @(negedge ref_clk);
		resetn = 1'b1;
		host.read_rec(REC_SPARE, r);
		check(r, mk(ID_SPARE, FLAGS_PREFAIL, PCT_FULL, PCT_FULL, 48'h0));
		host.read_rec(REC_ERASE, r);
		check(r, mk(ID_ERASE, FLAGS_PREFAIL, PCT_FULL, PCT_FULL, 48'h0));
		host.read_rec(REC_ECC_ALL, r);
		check(r, mk(ID_ECC_ALL, FLAGS_ADVISORY, PCT_FULL, PCT_FULL, 48'h0));
		st(8'd100, 8'd100, 1'b0);
	endtask

	// Main sequence: reset, events, then reads once two refresh passes have finished.
	initial
	begin
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		resetn = 1'b1;
		t_events();
		repeat (600) @(posedge ref_clk);
		t_spares();
		t_erase();
		t_invalid();
		t_status();
		t_reset();
		end_of_test();
	end

	// Watchdog: the sequence needs about 830 cycles.
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		end_of_test();
	end
endmodule
